// file: common/cpvsz_pkg.sv
// constants, register map and carrier types for the phase measurement block
package cpvsz_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_GAIN    = 8'h00;
   localparam logic [7:0] OFF_MEASUREMENT_MODE_REG   = 8'h04;
   localparam logic [7:0] OFF_LCYC    = 8'h08;
   localparam logic [7:0] OFF_OCTHR   = 8'h0C;
   localparam logic [7:0] OFF_WAVEFORM_MODE_REG = 8'h10;
   localparam logic [7:0] OFF_MASK    = 8'h14;
   localparam logic [7:0] OFF_STATUS  = 8'h18;
   localparam logic [7:0] OFF_CLEAR_ON_READ_STATUS = 8'h1C;
   localparam logic [7:0] OFF_WAVEFORM_SAMPLE_REG   = 8'h20;
   localparam logic [7:0] OFF_WBYTE   = 8'h24;
   localparam logic [7:0] OFF_CURRENT_PEAK_HOLD   = 8'h28;
   localparam logic [7:0] OFF_VOLTAGE_PEAK_HOLD   = 8'h2C;
   // reset values
   localparam logic [7:0]  GAIN_RST    = 8'h80;
   localparam logic [7:0]  MEASUREMENT_MODE_REG_RST   = 8'h1C;
   localparam logic [7:0]  LCYC_RST    = 8'h07;
   localparam logic [7:0]  OCTHR_RST   = 8'hFF;
   localparam logic [7:0]  WAVEFORM_MODE_REG_RST = 8'h00;
   localparam logic [16:0] MASK_RST    = 17'h00000;
   // field positions
   localparam int INTEG_BIT  = 7;
   localparam int PKSEL_LSB  = 2;
   localparam int OCSEL_LSB  = 5;
   localparam int ZERO_CROSS_PHASE_SELECT_LSB  = 0;
   localparam int WAVEFORM_PHASE_SELECT_LSB  = 0;
   localparam int WAVEFORM_SOURCE_SELECT_LSB = 2;
   localparam int DTRT_LSB   = 5;
   localparam int ST_ZX_LSB  = 9;
   localparam int ST_OC      = 15;
   localparam int ST_SAMPLE_READY_MASK    = 16;
   localparam int ST_W       = 17;
   // codes and counts
   localparam logic [2:0] WAVEFORM_SOURCE_SELECT_CUR    = 3'h0;
   localparam logic [2:0] WAVEFORM_SOURCE_SELECT_VOLT   = 3'h1;
   localparam logic [7:0] PEAK_HALF_CYC = 8'h04;
   localparam int         INT_SHIFT     = 6;
   localparam int         INT_LEAK      = 10;
   localparam int         LPF_SHIFT     = 4;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } cpvsz_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cpvsz_axi_rsp_t;

   // one strobe per 26 kSPS conversion for all three phases
   typedef struct packed {
      logic             stb;
      logic [2:0][23:0] cur;
      logic [2:0][15:0] volt;
   } cpvsz_adc_t;
endpackage : cpvsz_pkg

// file: design/cpvsz_meter.sv
// per-phase current peak, overcurrent, voltage waveform and zero-cross logic
`timescale 1ns/1ps

// Summary of operation
// - integrator enabled at reset; gain bit 7 switches it on.
// - integrator is leaky accumulator, -20 dB/dec with about 90 degree lag.
// - current peak holds largest absolute sample over fixed half-line cycles.
// - current peak holds bits 21:14 of absolute current sample.
// - peak phase select bits 4:2 pick phases for both voltage and current peaks.
// - half cycles counted from voltage crossings of zero-cross selected phases.
// - overcurrent threshold compared with bits 21:14 of current samples.
// - sample above threshold sets status bit 15; masked onto interrupt.
// - any phase enabled by overcurrent phase select may raise that flag.
// - no high-pass on voltage in any path.
// - waveform voltage passes single-pole low-pass near 260 Hz.
// - voltage waveform samples are 16-bit, sign extended to 24 bits.
// - smoothing filter only in waveform, crossing and voltage peak paths.
// - waveform mode bits 6:5 choose one of four output rates.
// - new waveform sample sets ready flag; interrupt if masked in.
// - waveform sample read as three bytes, most significant first.
// - each phase has a crossing detector fed from the filter output.
// - crossing signal drives half-cycle count and crossing interrupt.
// - only negative-to-positive crossing sets phase flag in bits 11:9.
// - crossing flag asserts interrupt only when its mask bit is one.
// - reading clear-on-read status clears flags; one flag, mask per phase.
// - interrupt stays low until clear-on-read status is read or a mask write masks off the set flags.
module cpvsz_meter (
   input  wire logic                     ref_clk,
   input  wire logic                     srst,
   input  wire cpvsz_pkg::cpvsz_axi_req_t axiReq,
   output cpvsz_pkg::cpvsz_axi_rsp_t     axiRsp,
   input  wire cpvsz_pkg::cpvsz_adc_t     adc,
   output logic                          irqN
);
   import cpvsz_pkg::*;

   typedef struct packed {
      logic [7:0]       gain;
      logic [7:0]       measurement_mode_reg;
      logic [7:0]       lcyc;
      logic [7:0]       ocThr;
      logic [7:0]       waveform_mode_reg;
      logic [ST_W-1:0]  mask;
      logic [ST_W-1:0]  status;
      logic [23:0]      waveform_sample_reg;
      logic [1:0]       bytePtr;
      logic [7:0]       current_peak_hold;
      logic [7:0]       voltage_peak_hold;
      logic [7:0]       ipeakRun;
      logic [7:0]       vpeakRun;
      logic [7:0]       halfCnt;
      logic [2:0][23:0] integ;
      logic [2:0][19:0] vfilt;
      logic [2:0]       vsign;
      logic [2:0]       decim;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic             irqN;
   } cpvsz_state_t;

   cpvsz_state_t q_r;
   cpvsz_state_t q_nxt;

   logic              wrAcc;
   logic              rdAcc;
   logic              clrRead;
   logic [2:0]        posCross;
   logic [2:0]        anyCross;
   logic              ocHit;
   logic              halfInc;
   logic              newSample;
   logic [ST_W-1:0]   setBits;
   logic [7:0]        wrAddr;
   logic [7:0]        rdAddr;
   logic [31:0]       wrWord;
   logic [2:0]        rateMask;
   logic [1:0]        ph;

   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   always_comb begin
      logic signed [23:0] curS;
      logic        [23:0] absI;
      logic signed [15:0] vS;
      logic        [15:0] absV;
      logic signed [20:0] vdiff;
      logic signed [23:0] iacc;
      logic        [7:0]  fieldI;
      logic        [7:0]  fieldV;
      curS     = '0;
      absI     = '0;
      vS       = '0;
      absV     = '0;
      vdiff    = '0;
      iacc     = '0;
      fieldI   = '0;
      fieldV   = '0;
      q_nxt    = q_r;
      posCross = '0;
      anyCross = '0;
      ocHit    = 1'b0;
      halfInc  = 1'b0;
      newSample = 1'b0;
      setBits  = '0;
      wrAcc    = axiReq.awvalid & axiReq.wvalid & ~q_r.bvalid;
      rdAcc    = axiReq.arvalid & ~q_r.rvalid;
      wrAddr   = {axiReq.awaddr[7:2], 2'h0};
      rdAddr   = {axiReq.araddr[7:2], 2'h0};
      clrRead  = rdAcc && (rdAddr == OFF_CLEAR_ON_READ_STATUS) && (axiReq.araddr[31:8] == 24'h0);
      wrWord   = lane_merge(32'h0, axiReq.wdata, axiReq.wstrb);
      rateMask = 3'((4'h1 << q_r.waveform_mode_reg[DTRT_LSB +: 2]) - 4'h1);
      ph       = q_r.waveform_mode_reg[WAVEFORM_PHASE_SELECT_LSB +: 2];

      // per-phase signal processing, once per conversion
      if (adc.stb) begin
         for (int p = 0; p < 3; p++) begin
            // leaky integration for rate-of-change sensors
            iacc = $signed(q_r.integ[p]) + ($signed(adc.cur[p]) >>> INT_SHIFT)
                   - ($signed(q_r.integ[p]) >>> INT_LEAK);
            q_nxt.integ[p] = iacc;
            curS = q_r.gain[INTEG_BIT] ? $signed(q_r.integ[p])
                                       : $signed(adc.cur[p]);
            absI = curS[23] ? 24'(-curS) : curS;
            fieldI = absI[21:14];
            // smoothing only feeds waveform, crossings and voltage peak; raw path untouched
            vdiff = $signed({adc.volt[p], 4'h0}) - $signed(q_r.vfilt[p]);
            q_nxt.vfilt[p] = 20'($signed(q_r.vfilt[p]) + (vdiff >>> LPF_SHIFT));
            vS = $signed(q_r.vfilt[p][19:4]);
            absV = vS[15] ? 16'(-vS) : vS;
            fieldV = absV[13:6];
            q_nxt.vsign[p] = q_r.vfilt[p][19];
            posCross[p] = q_r.vsign[p] & ~q_r.vfilt[p][19];
            anyCross[p] = q_r.vsign[p] ^ q_r.vfilt[p][19];
            if (q_r.measurement_mode_reg[OCSEL_LSB + p] && (fieldI > q_r.ocThr)) begin
               ocHit = 1'b1;
            end
            if (q_r.measurement_mode_reg[PKSEL_LSB + p]) begin
               if (fieldI > q_nxt.ipeakRun) begin
                  q_nxt.ipeakRun = fieldI;
               end
               if (fieldV > q_nxt.vpeakRun) begin
                  q_nxt.vpeakRun = fieldV;
               end
            end
            if (anyCross[p] && q_r.lcyc[ZERO_CROSS_PHASE_SELECT_LSB + p]) begin
               halfInc = 1'b1;
            end
         end
         if (halfInc) begin
            if (q_r.halfCnt + 8'h01 >= PEAK_HALF_CYC) begin
               q_nxt.current_peak_hold    = q_nxt.ipeakRun;
               q_nxt.voltage_peak_hold    = q_nxt.vpeakRun;
               q_nxt.ipeakRun = '0;
               q_nxt.vpeakRun = '0;
               q_nxt.halfCnt  = '0;
            end else begin
               q_nxt.halfCnt = q_r.halfCnt + 8'h01;
            end
         end
         // waveform decimation and capture
         q_nxt.decim = q_r.decim + 3'h1;
         if (((q_r.decim & rateMask) == 3'h0) && (ph != 2'h3)) begin
            if (q_r.waveform_mode_reg[WAVEFORM_SOURCE_SELECT_LSB +: 3] == WAVEFORM_SOURCE_SELECT_VOLT) begin
               vS = $signed(q_r.vfilt[ph][19:4]);
               q_nxt.waveform_sample_reg = {{8{vS[15]}}, vS};
               newSample = 1'b1;
            end else if (q_r.waveform_mode_reg[WAVEFORM_SOURCE_SELECT_LSB +: 3] == WAVEFORM_SOURCE_SELECT_CUR) begin
               q_nxt.waveform_sample_reg = q_r.gain[INTEG_BIT] ? q_r.integ[ph] : adc.cur[ph];
               newSample = 1'b1;
            end
         end
         if (newSample) begin
            q_nxt.bytePtr = 2'h0;
         end
      end

      setBits[ST_ZX_LSB +: 3] = posCross;
      setBits[ST_OC]          = ocHit;
      setBits[ST_SAMPLE_READY_MASK]        = newSample;

      // register writes
      if (wrAcc) begin
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp  = RESP_OKAY;
         if (axiReq.awaddr[31:8] != 24'h0) begin
            q_nxt.bresp = RESP_SLVERR;
         end else begin
            case (wrAddr)
               OFF_GAIN:    q_nxt.gain    = lane_merge({24'h0, q_r.gain}, axiReq.wdata,
                                                       axiReq.wstrb) [7:0];
               OFF_MEASUREMENT_MODE_REG:   q_nxt.measurement_mode_reg   = lane_merge({24'h0, q_r.measurement_mode_reg}, axiReq.wdata,
                                                       axiReq.wstrb) [7:0];
               OFF_LCYC:    q_nxt.lcyc    = lane_merge({24'h0, q_r.lcyc}, axiReq.wdata,
                                                       axiReq.wstrb) [7:0];
               OFF_OCTHR:   q_nxt.ocThr   = lane_merge({24'h0, q_r.ocThr}, axiReq.wdata,
                                                       axiReq.wstrb) [7:0];
               OFF_WAVEFORM_MODE_REG: q_nxt.waveform_mode_reg = lane_merge({24'h0, q_r.waveform_mode_reg}, axiReq.wdata,
                                                       axiReq.wstrb) [7:0];
               OFF_MASK:    q_nxt.mask    = lane_merge({15'h0, q_r.mask}, axiReq.wdata,
                                                       axiReq.wstrb) [ST_W-1:0];
               OFF_STATUS, OFF_CLEAR_ON_READ_STATUS, OFF_WAVEFORM_SAMPLE_REG, OFF_WBYTE, OFF_CURRENT_PEAK_HOLD, OFF_VOLTAGE_PEAK_HOLD: begin
                  q_nxt.bresp = RESP_OKAY;
               end
               default:     q_nxt.bresp   = RESP_SLVERR;
            endcase
         end
      end else if (axiReq.bready) begin
         q_nxt.bvalid = 1'b0;
      end

      // register reads
      if (rdAcc) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rresp  = RESP_OKAY;
         q_nxt.rdata  = 32'h0;
         if (axiReq.araddr[31:8] != 24'h0) begin
            q_nxt.rresp = RESP_SLVERR;
         end else begin
            case (rdAddr)
               OFF_GAIN:    q_nxt.rdata = {24'h0, q_r.gain};
               OFF_MEASUREMENT_MODE_REG:   q_nxt.rdata = {24'h0, q_r.measurement_mode_reg};
               OFF_LCYC:    q_nxt.rdata = {24'h0, q_r.lcyc};
               OFF_OCTHR:   q_nxt.rdata = {24'h0, q_r.ocThr};
               OFF_WAVEFORM_MODE_REG: q_nxt.rdata = {24'h0, q_r.waveform_mode_reg};
               OFF_MASK:    q_nxt.rdata = {15'h0, q_r.mask};
               OFF_STATUS, OFF_CLEAR_ON_READ_STATUS: q_nxt.rdata = {15'h0, q_r.status};
               OFF_WAVEFORM_SAMPLE_REG:   q_nxt.rdata = {8'h0, q_r.waveform_sample_reg};
               OFF_WBYTE: begin
                  // byte stream, most significant first
                  case (q_r.bytePtr)
                     2'h0:    q_nxt.rdata = {24'h0, q_r.waveform_sample_reg[23:16]};
                     2'h1:    q_nxt.rdata = {24'h0, q_r.waveform_sample_reg[15:8]};
                     default: q_nxt.rdata = {24'h0, q_r.waveform_sample_reg[7:0]};
                  endcase
                  if (!newSample) begin
                     q_nxt.bytePtr = (q_r.bytePtr == 2'h2) ? 2'h0 : q_r.bytePtr + 2'h1;
                  end
               end
               OFF_CURRENT_PEAK_HOLD:   q_nxt.rdata = {24'h0, q_r.current_peak_hold};
               OFF_VOLTAGE_PEAK_HOLD:   q_nxt.rdata = {24'h0, q_r.voltage_peak_hold};
               default:     q_nxt.rresp = RESP_SLVERR;
            endcase
         end
      end else if (axiReq.rready) begin
         q_nxt.rvalid = 1'b0;
      end

      // sticky flags: a new event beats the clearing read
      q_nxt.status = (q_r.status & ~(clrRead ? {ST_W{1'b1}} : {ST_W{1'b0}})) | setBits;
      q_nxt.irqN   = ~|(q_nxt.status & q_nxt.mask);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q_r         <= '0;
         q_r.gain    <= GAIN_RST;
         q_r.measurement_mode_reg   <= MEASUREMENT_MODE_REG_RST;
         q_r.lcyc    <= LCYC_RST;
         q_r.ocThr   <= OCTHR_RST;
         q_r.waveform_mode_reg <= WAVEFORM_MODE_REG_RST;
         q_r.mask    <= MASK_RST;
         q_r.irqN    <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign axiRsp.awready = wrAcc;
   assign axiRsp.wready  = wrAcc;
   assign axiRsp.bvalid  = q_r.bvalid;
   assign axiRsp.bresp   = q_r.bresp;
   assign axiRsp.arready = ~q_r.rvalid;
   assign axiRsp.rvalid  = q_r.rvalid;
   assign axiRsp.rdata   = q_r.rdata;
   assign axiRsp.rresp   = q_r.rresp;
   assign irqN           = q_r.irqN;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   AST_INTEG_AFTER_RESET: assert property ($fell(srst) |-> q_r.gain[INTEG_BIT])
      else $error("integrator not enabled after reset");
   AST_OC_SETS_FLAG: assert property (ocHit |=> q_r.status[ST_OC])
      else $error("overcurrent did not set flag");
   AST_OC_CAUSE: assert property ($rose(q_r.status[ST_OC]) |-> $past(ocHit))
      else $error("overcurrent flag without enabled phase hit");
   AST_ZX_SETS_FLAG: assert property (posCross[0] |=> q_r.status[ST_ZX_LSB])
      else $error("rising crossing did not set flag");
   AST_ZX_ONLY_RISING: assert property ($rose(q_r.status[ST_ZX_LSB + 1])
                                        |-> $past(posCross[1]))
      else $error("crossing flag set without rising crossing");
   AST_CLEAR_ON_READ: assert property (clrRead && !(|posCross) |=>
                                       q_r.status[ST_ZX_LSB +: 3] == 3'h0)
      else $error("crossing flags not cleared by status read");
   AST_WAVEFORM_SAMPLE_REG_SIGN: assert property (newSample && q_r.waveform_mode_reg[WAVEFORM_SOURCE_SELECT_LSB +: 3] == WAVEFORM_SOURCE_SELECT_VOLT
                                    |=> q_r.waveform_sample_reg[23:16] == {8{q_r.waveform_sample_reg[15]}})
      else $error("voltage sample not sign extended");
   AST_SAMPLE_READY: assert property (newSample && q_r.mask[ST_SAMPLE_READY_MASK] && !wrAcc |=> !irqN)
      else $error("sample ready did not assert interrupt");
   AST_IRQ_HOLD: assert property (!irqN && !clrRead && !wrAcc |=> !irqN)
      else $error("interrupt released without clearing read");
   AST_IRQ_MASKED: assert property (!irqN |-> |(q_r.status & q_r.mask))
      else $error("interrupt low with no unmasked flag");

   COV_OC_IRQ: cover property (ocHit ##1 !irqN);
   COV_ZX_FLAG: cover property (|posCross ##1 |q_r.status[ST_ZX_LSB +: 3]);
   COV_SAMPLE_READY_MASK: cover property (newSample ##[1:4] clrRead);
   COV_PEAK_UPD: cover property (halfInc && q_r.halfCnt == PEAK_HALF_CYC - 8'h01);
endmodule : cpvsz_meter

// file: verification/cpvsz_host_model.sv
// register bus master model standing in for the host controller
`timescale 1ns/1ps
module cpvsz_host_model (
   input  wire logic                      ref_clk,
   output cpvsz_pkg::cpvsz_axi_req_t      axiReq,
   input  wire cpvsz_pkg::cpvsz_axi_rsp_t axiRsp
);
   import cpvsz_pkg::*;

   initial axiReq = '0;

   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr  <= a;
      axiReq.wvalid  <= 1'b1;
      axiReq.wdata   <= d;
      axiReq.wstrb   <= 4'hF;
      axiReq.bready  <= 1'b1;
      @(negedge ref_clk);
      while (axiRsp.awready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      axiReq.awvalid <= 1'b0;
      axiReq.wvalid  <= 1'b0;
      // released payload no longer shows the old value
      axiReq.awaddr  <= ~a;
      axiReq.wdata   <= ~d;
      @(negedge ref_clk);
      while (axiRsp.bvalid !== 1'b1) @(negedge ref_clk);
      r = axiRsp.bresp;
      @(posedge ref_clk);
      axiReq.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr  <= a;
      axiReq.rready  <= 1'b1;
      @(negedge ref_clk);
      while (axiRsp.arready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      axiReq.arvalid <= 1'b0;
      axiReq.araddr  <= ~a;
      @(negedge ref_clk);
      while (axiRsp.rvalid !== 1'b1) @(negedge ref_clk);
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge ref_clk);
      axiReq.rready <= 1'b0;
   endtask : rd
endmodule : cpvsz_host_model

// file: verification/cpvsz_tb.sv
// self-checking testbench for the phase measurement block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
   import cpvsz_pkg::*;

   logic                   ref_clk;
   logic                   srst;
   cpvsz_axi_req_t         axiReq;
   cpvsz_axi_rsp_t         axiRsp;
   cpvsz_adc_t             adc;
   logic                   irqN;
   int                     errors;
   int                     comparisons;

   cpvsz_meter dut_u (.ref_clk(ref_clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
                      .adc(adc), .irqN(irqN));
   cpvsz_host_model host_u (.ref_clk(ref_clk), .axiReq(axiReq), .axiRsp(axiRsp));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      host_u.rd({24'h0, a}, d, r);
      `CHK(nm, e, d & m)
      `CHK("rresp", RESP_OKAY, r)
   endtask : rchk

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      host_u.wr({24'h0, a}, d, r);
      `CHK("bresp", RESP_OKAY, r)
   endtask : wreg

   task automatic irqchk(input string nm, input logic e);
      @(negedge ref_clk);
      `CHK(nm, e, irqN)
   endtask : irqchk

   // one conversion strobe every second cycle
   task automatic feed(input int n, input logic [2:0][15:0] v, input logic [2:0][23:0] c);
      adc.volt <= v;
      adc.cur  <= c;
      repeat (n) begin
         @(posedge ref_clk);
         adc.stb <= 1'b1;
         @(posedge ref_clk);
         adc.stb <= 1'b0;
      end
   endtask : feed

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  r;
      rchk("gain", OFF_GAIN, 32'h000000FF, 32'h00000080);
      rchk("measurement_mode_reg", OFF_MEASUREMENT_MODE_REG, 32'h000000FF, 32'h0000001C);
      rchk("lcyc", OFF_LCYC, 32'h000000FF, 32'h00000007);
      rchk("octhr", OFF_OCTHR, 32'h000000FF, 32'h000000FF);
      rchk("waveform_mode_reg", OFF_WAVEFORM_MODE_REG, 32'h000000FF, 32'h00000000);
      rchk("mask", OFF_MASK, 32'h0001FFFF, 32'h00000000);
      host_u.rd(32'h00000030, d, r);
      `CHK("unmapped resp", RESP_SLVERR, r)
      host_u.rd(32'h00000104, d, r);
      `CHK("high address resp", RESP_SLVERR, r)
      wreg(OFF_WAVEFORM_SAMPLE_REG, 32'h00000000);
      irqchk("irq idle", 1'b1);
   endtask : t_reset

   task automatic t_overcur();
      wreg(OFF_OCTHR, 32'h00000010);
      wreg(OFF_MEASUREMENT_MODE_REG, 32'h0000003C);
      wreg(OFF_MASK, 32'h00008000);
      // integrator on: first sample only seeds the accumulator
      feed(1, '0, {24'h0, 24'h0, 24'h2851EC});
      rchk("oc integ on", OFF_STATUS, 32'h00008000, 32'h00000000);
      wreg(OFF_GAIN, 32'h00000000);
      rchk("clear", OFF_CLEAR_ON_READ_STATUS, 32'h00000000, 32'h00000000);
      feed(1, '0, {24'h0, 24'h2851EC, 24'h0});
      rchk("oc unselected", OFF_STATUS, 32'h00008000, 32'h00000000);
      feed(1, '0, {24'h0, 24'h0, 24'h0403FF});
      rchk("oc equal", OFF_STATUS, 32'h00008000, 32'h00000000);
      feed(1, '0, {24'h0, 24'h0, 24'h044000});
      irqchk("irq oc", 1'b0);
      rchk("oc flag", OFF_STATUS, 32'h00008000, 32'h00008000);
      irqchk("irq held", 1'b0);
      rchk("oc clear_on_read_status", OFF_CLEAR_ON_READ_STATUS, 32'h00008000, 32'h00008000);
      irqchk("irq released", 1'b1);
      wreg(OFF_MASK, 32'h00000000);
      feed(1, '0, {24'h0, 24'h0, 24'h044000});
      irqchk("irq masked", 1'b1);
      rchk("oc masked", OFF_CLEAR_ON_READ_STATUS, 32'h00008000, 32'h00008000);
   endtask : t_overcur

   task automatic t_peak();
      wreg(OFF_MEASUREMENT_MODE_REG, 32'h00000008);
      wreg(OFF_LCYC, 32'h00000001);
      for (int h = 0; h < 12; h++) begin
         if (h % 2 == 1) feed(40, {16'h0, 16'h1040, 16'h2000}, {24'h0, 24'h2851EC, 24'h3FFFFF});
         else feed(40, {16'h0, 16'h1040, 16'hE000}, {24'h0, 24'hD7AE14, 24'h3FFFFF});
      end
      rchk("current peak", OFF_CURRENT_PEAK_HOLD, 32'h000000FF, 32'h000000A1);
      rchk("voltage peak", OFF_VOLTAGE_PEAK_HOLD, 32'h000000FF, 32'h00000040);
   endtask : t_peak

   task automatic t_zerocross();
      logic [2:0][15:0] pos;
      logic [2:0][15:0] neg;
      wreg(OFF_MASK, 32'h00000E00);
      for (int p = 0; p < 3; p++) begin
         pos = '0;
         neg = '0;
         pos[p] = 16'h2000;
         neg[p] = 16'hE000;
         feed(40, pos, '0);
         rchk("clear", OFF_CLEAR_ON_READ_STATUS, 32'h00000000, 32'h00000000);
         feed(40, neg, '0);
         rchk("falling", OFF_STATUS, 32'h00000E00, 32'h00000000);
         // one positive spike is smoothed away before detection
         feed(1, pos, '0);
         feed(10, neg, '0);
         rchk("spike", OFF_STATUS, 32'h00000E00, 32'h00000000);
         irqchk("irq quiet", 1'b1);
         feed(40, pos, '0);
         irqchk("irq rising", 1'b0);
         rchk("rising", OFF_CLEAR_ON_READ_STATUS, 32'h00000E00, 32'h00000200 << p);
         irqchk("irq acked", 1'b1);
         rchk("cleared", OFF_STATUS, 32'h00000E00, 32'h00000000);
      end
   endtask : t_zerocross

   task automatic t_wave();
      wreg(OFF_MASK, 32'h00010000);
      wreg(OFF_WAVEFORM_MODE_REG, 32'h00000005);
      feed(300, {16'h0, 16'hD8B8, 16'h0}, '0);
      irqchk("irq sample", 1'b0);
      rchk("waveform", OFF_WAVEFORM_SAMPLE_REG, 32'hFFFFFFFF, 32'h00FFD8B8);
      rchk("byte msb", OFF_WBYTE, 32'h000000FF, 32'h000000FF);
      rchk("byte mid", OFF_WBYTE, 32'h000000FF, 32'h000000D8);
      rchk("byte lsb", OFF_WBYTE, 32'h000000FF, 32'h000000B8);
      rchk("ready flag", OFF_CLEAR_ON_READ_STATUS, 32'h00010000, 32'h00010000);
      irqchk("irq sample acked", 1'b1);
   endtask : t_wave

   initial begin
      errors = 0;
      comparisons = 0;
      srst = 1'b1;
      adc = '0;
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_overcur();
      t_peak();
      t_zerocross();
      t_wave();
      stop_test();
   end

   // whole sequence needs roughly 2600 cycles
   initial begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      stop_test();
   end
endmodule : tb
